// ==== core/fbp_pkg.sv ====
// shared constants and carrier types of the sector-protect and status block
// assumes one 20 MHz system clock and a serial host framed by chip select
package fbp_pkg;
   // ==========================================================
   // array geometry and protect decode
   localparam int SECTOR_W = 11;
   localparam logic [3:0] PROT_ALL_CODE = 4'hC;
   // ==========================================================
   // serial commands
   localparam logic [7:0] CMD_WR_ENABLE = 8'h06;
   localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
   localparam logic [7:0] CMD_WR_STATUS = 8'h01;
   localparam logic [7:0] CMD_RD_STATUS = 8'h05;
   localparam logic [7:0] CMD_RD_FLAGS = 8'h70;
   // ==========================================================
   // status register layout
   localparam int SR_WIP = 0;
   localparam int SR_WEL = 1;
   localparam int SR_BP0 = 2;
   localparam int SR_TB = 5;
   localparam int SR_BP3 = 6;
   localparam logic [3:0] BP_RESET = 4'h0;
   localparam logic TB_RESET = 1'b0;
   // ==========================================================
   // flag status layout
   localparam int FS_READY = 7;
   localparam int FS_ERASE_SUSP = 6;
   localparam int FS_ERASE_ERR = 5;
   localparam int FS_PROG_ERR = 4;
   localparam int FS_PROG_SUSP = 2;
   localparam int FS_PROT_ERR = 1;
   localparam int FS_ADDR4 = 0;
   // ==========================================================
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int STATUS_WRITE_TIME_MS = 5;
   localparam int STATUS_WRITE_MAX_MS = 8;
   localparam int STATUS_WRITE_CYCLES = CLK_HZ / 1000 * STATUS_WRITE_TIME_MS;
   localparam int STATUS_WRITE_MAX_CYCLES = CLK_HZ / 1000 * STATUS_WRITE_MAX_MS - 1;
   // ==========================================================
   // carriers
   typedef struct packed {
      logic valid;
      logic erase;
      logic [SECTOR_W-1:0] sector;
   } fbp_op_req_t;
   typedef struct packed {
      logic grant;
      logic deny;
   } fbp_op_rsp_t;
   typedef struct packed {
      logic nvcrBusy;
      logic progBusy;
      logic eraseBusy;
      logic eraseSusp;
      logic progSusp;
      logic eraseFail;
      logic progFail;
      logic addr4;
   } fbp_dev_state_t;
endpackage

// ==== core/fbp_protect_status.sv ====
// sector protect decode, self-timed status write and flag status reporting
// assumes serial pins are asynchronous; array datapath sits on clk_sys
//
// Behaviour
// - top select 0: code 1..11 protects top 2^(n-1) sectors; 12..15 all; 0 none
// - top select 1: code 1..11 protects bottom 2^(n-1) sectors; 12..15 all; 0 none
// - protected sectors are read-only; program or erase refused
// - status write sets protect and top select bits, not WEL or WIP
// - flag bit 7 is 0 during status write, 1 afterwards
// - self-timed status write starts when chip select rises
// - status write takes typically 5 ms, always under 8 ms
// - write-in-progress is 1 during the status write cycle, then 0
// - flag bit 7 reads busy during any write or erase operation
// - flag bits 6 and 2 show erase and program suspend; bit 3 reserved
// - flag bit 5 shows erase failure or protection error
// - flag bit 4 shows program failure or protection error
// - flag bit 1 shows attempt to modify a protected sector
// - flag bit 0 shows four-byte addressing mode
// - flag status readable at any moment, including during operations
// - ready flag always equals inverse of write-in-progress
`timescale 1ns/1ps
module fbp_protect_status import fbp_pkg::*; #(
   parameter int unsigned STATUS_CYCLES = STATUS_WRITE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic chipSelectLowN,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   output logic misoOe,
   input wire fbp_dev_state_t devState,
   input wire fbp_op_req_t opReq,
   output fbp_op_rsp_t opRsp
);
   localparam int CNT_W = $clog2(STATUS_CYCLES + 1);

   function automatic logic isProt(input logic tb, input logic [3:0] code, input logic [SECTOR_W-1:0] sec);
      logic [SECTOR_W-1:0] mask;
      logic hit;
      mask = {SECTOR_W{1'b1}} << (4'(code - 4'h1));
      if (code == 4'h0) begin
         hit = 1'b0;
      end else if (code >= PROT_ALL_CODE) begin
         hit = 1'b1;
      end else if (tb) begin
         hit = ((sec & mask) == '0);
      end else begin
         hit = ((sec & mask) == mask);
      end
      return hit;
   endfunction

   // ==========================================================
   // pin synchronisers and link frame
   logic sckMeta_r, sckSync_r, sckPrev_r, csMeta_r, csSync_r, csPrev_r, mosiMeta_r, mosiSync_r;
   logic [2:0] bitCnt_r, bitCnt_nxt;
   logic [1:0] byteCnt_r, byteCnt_nxt;
   logic [7:0] shift_r, shift_nxt, cmd_r, cmd_nxt, wrData_r, wrData_nxt, tx_r, tx_nxt;
   logic sckRise, sckFall, csEnd, reading;
   logic [7:0] statusByte, flagByte;

   assign sckRise = sckSync_r & ~sckPrev_r;
   assign sckFall = ~sckSync_r & sckPrev_r;
   assign csEnd = csSync_r & ~csPrev_r;
   assign reading = (cmd_r == CMD_RD_STATUS) || (cmd_r == CMD_RD_FLAGS);

   always_comb begin
      bitCnt_nxt = bitCnt_r;
      byteCnt_nxt = byteCnt_r;
      shift_nxt = shift_r;
      cmd_nxt = cmd_r;
      wrData_nxt = wrData_r;
      tx_nxt = tx_r;
      if (csSync_r) begin
         bitCnt_nxt = 3'h0;
         byteCnt_nxt = 2'h0;
      end else if (sckRise) begin
         shift_nxt = {shift_r[6:0], mosiSync_r};
         bitCnt_nxt = 3'(bitCnt_r + 3'h1);
         if (bitCnt_r == 3'h7) begin
            if (byteCnt_r == 2'h0) begin
               cmd_nxt = shift_nxt;
            end
            if (byteCnt_r == 2'h1 && cmd_r == CMD_WR_STATUS) begin
               wrData_nxt = shift_nxt;
            end
            if (byteCnt_r != 2'h3) begin
               byteCnt_nxt = 2'(byteCnt_r + 2'h1);
            end
         end
      end else if (sckFall) begin
         // reload each byte so a held frame keeps tracking live state
         if (reading && byteCnt_r != 2'h0 && bitCnt_r == 3'h0) begin
            tx_nxt = (cmd_r == CMD_RD_FLAGS) ? flagByte : statusByte;
         end else begin
            tx_nxt = {tx_r[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sckMeta_r <= 1'b0;
         sckSync_r <= 1'b0;
         sckPrev_r <= 1'b0;
         csMeta_r <= 1'b1;
         csSync_r <= 1'b1;
         csPrev_r <= 1'b1;
         mosiMeta_r <= 1'b0;
         mosiSync_r <= 1'b0;
         bitCnt_r <= 3'h0;
         byteCnt_r <= 2'h0;
         shift_r <= 8'h00;
         cmd_r <= 8'h00;
         wrData_r <= 8'h00;
         tx_r <= 8'h00;
      end else begin
         sckMeta_r <= sclk;
         sckSync_r <= sckMeta_r;
         sckPrev_r <= sckSync_r;
         csMeta_r <= chipSelectLowN;
         csSync_r <= csMeta_r;
         csPrev_r <= csSync_r;
         mosiMeta_r <= mosi;
         mosiSync_r <= mosiMeta_r;
         bitCnt_r <= bitCnt_nxt;
         byteCnt_r <= byteCnt_nxt;
         shift_r <= shift_nxt;
         cmd_r <= cmd_nxt;
         wrData_r <= wrData_nxt;
         tx_r <= tx_nxt;
      end
   end

   assign miso = tx_r[7];
   assign misoOe = ~csSync_r & reading & (byteCnt_r != 2'h0);

   // ==========================================================
   // status register, timed write and flags
   logic wel_r, wel_nxt, swBusy_r, swBusy_nxt, tb_r, tb_nxt;
   logic eraseErr_r, eraseErr_nxt, progErr_r, progErr_nxt, protErr_r, protErr_nxt;
   logic [3:0] bp_r, bp_nxt;
   logic [7:0] pend_r, pend_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic wip, oneByteEnd, wrsrEnd, opProt, wrsrStart;

   // external busy keeps ready and WIP tied together for every operation
   assign wip = swBusy_r | devState.nvcrBusy | devState.progBusy | devState.eraseBusy;
   assign oneByteEnd = csEnd && byteCnt_r == 2'h1 && bitCnt_r == 3'h0;
   assign wrsrEnd = csEnd && byteCnt_r == 2'h2 && bitCnt_r == 3'h0 && cmd_r == CMD_WR_STATUS;
   assign wrsrStart = wrsrEnd && wel_r && !wip;
   assign opProt = isProt(tb_r, bp_r, opReq.sector);

   always_comb begin
      statusByte = 8'h00;
      statusByte[SR_WIP] = wip;
      statusByte[SR_WEL] = wel_r;
      statusByte[SR_BP0 +: 3] = bp_r[2:0];
      statusByte[SR_TB] = tb_r;
      statusByte[SR_BP3] = bp_r[3];
      flagByte = 8'h00;
      flagByte[FS_READY] = ~wip;
      flagByte[FS_ERASE_SUSP] = devState.eraseSusp;
      flagByte[FS_ERASE_ERR] = eraseErr_r | devState.eraseFail;
      flagByte[FS_PROG_ERR] = progErr_r | devState.progFail;
      flagByte[FS_PROG_SUSP] = devState.progSusp;
      flagByte[FS_PROT_ERR] = protErr_r;
      flagByte[FS_ADDR4] = devState.addr4;
   end

   // refusal is combinational so the array never sees a protected target
   assign opRsp = '{grant: opReq.valid & ~opProt, deny: opReq.valid & opProt};

   always_comb begin
      wel_nxt = wel_r;
      swBusy_nxt = swBusy_r;
      tb_nxt = tb_r;
      bp_nxt = bp_r;
      pend_nxt = pend_r;
      cnt_nxt = cnt_r;
      eraseErr_nxt = eraseErr_r;
      progErr_nxt = progErr_r;
      protErr_nxt = protErr_r;
      if (oneByteEnd && !wip && cmd_r == CMD_WR_ENABLE) begin
         wel_nxt = 1'b1;
         eraseErr_nxt = 1'b0;
         progErr_nxt = 1'b0;
         protErr_nxt = 1'b0;
      end
      if (oneByteEnd && !wip && cmd_r == CMD_WR_DISABLE) begin
         wel_nxt = 1'b0;
      end
      if (wrsrStart) begin
         swBusy_nxt = 1'b1;
         cnt_nxt = '0;
         pend_nxt = wrData_r;
      end
      if (swBusy_r) begin
         cnt_nxt = CNT_W'(cnt_r + 1'b1);
         if (cnt_r == CNT_W'(STATUS_CYCLES - 1)) begin
            swBusy_nxt = 1'b0;
            wel_nxt = 1'b0;
            // only protect and select bits are taken from the data byte
            bp_nxt = {pend_r[SR_BP3], pend_r[SR_BP0 +: 3]};
            tb_nxt = pend_r[SR_TB];
         end
      end
      // a refused operation sets its flags after any clear in the same cycle
      if (opRsp.deny) begin
         protErr_nxt = 1'b1;
         if (opReq.erase) begin
            eraseErr_nxt = 1'b1;
         end else begin
            progErr_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wel_r <= 1'b0;
         swBusy_r <= 1'b0;
         tb_r <= TB_RESET;
         bp_r <= BP_RESET;
         pend_r <= 8'h00;
         cnt_r <= '0;
         eraseErr_r <= 1'b0;
         progErr_r <= 1'b0;
         protErr_r <= 1'b0;
      end else begin
         wel_r <= wel_nxt;
         swBusy_r <= swBusy_nxt;
         tb_r <= tb_nxt;
         bp_r <= bp_nxt;
         pend_r <= pend_nxt;
         cnt_r <= cnt_nxt;
         eraseErr_r <= eraseErr_nxt;
         progErr_r <= progErr_nxt;
         protErr_r <= protErr_nxt;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   a_ready_not_wip: assert property (flagByte[FS_READY] == ~statusByte[SR_WIP])
      else $error("ready flag differs from inverse of wip");
   a_start_on_cs: assert property (wrsrStart |=> swBusy_r && cnt_r == '0)
      else $error("status write did not start on chip select rise");
   a_start_needs_wel: assert property ($rose(swBusy_r) |-> $past(wel_r))
      else $error("status write started without write enable");
   a_busy_flag_low: assert property (swBusy_r |-> !flagByte[FS_READY] && statusByte[SR_WIP])
      else $error("busy write not shown in flags");
   a_write_length: assert property ($fell(swBusy_r) |-> $past(cnt_r) == CNT_W'(STATUS_CYCLES - 1))
      else $error("status write length wrong");
   a_wip_clears: assert property ($fell(swBusy_r) && !devState.progBusy && !devState.eraseBusy
      && !devState.nvcrBusy |-> !statusByte[SR_WIP] && flagByte[FS_READY])
      else $error("wip not cleared after status write");
   a_bp_update: assert property ($fell(swBusy_r) |-> bp_r == {$past(pend_r[SR_BP3]), $past(pend_r[4:2])}
      && tb_r == $past(pend_r[SR_TB]) && !wel_r)
      else $error("protect bits not loaded from status data");
   a_top_deny: assert property (opReq.valid && !tb_r && bp_r == 4'h7 && opReq.sector >= 11'h7C0
      |-> opRsp.deny && !opRsp.grant)
      else $error("top protected sector not refused");
   a_bottom_pass: assert property (opReq.valid && tb_r && bp_r == 4'h1 && opReq.sector != 11'h000
      |-> opRsp.grant)
      else $error("unprotected sector refused");
   a_deny_flags: assert property (opRsp.deny && opReq.erase |=> protErr_r && flagByte[FS_ERASE_ERR])
      else $error("refused erase did not set flags");

   c_status_write: cover property ($fell(swBusy_r));
   c_refused_prog: cover property (opRsp.deny && !opReq.erase);
   c_flag_read: cover property (sckFall && cmd_r == CMD_RD_FLAGS && byteCnt_r == 2'h1 && bitCnt_r == 3'h0);
endmodule

// ==== verification/fbp_host_model.sv ====
// host side of the serial link: frames commands on chip select, mode 0
// assumes clk_sys pacing; sclk half period is four system clocks, 400 ns period
`timescale 1ns/1ps
module fbp_host_model import fbp_pkg::*; (
   input wire logic clk_sys,
   input wire logic miso,
   output logic chipSelectLowN,
   output logic sclk,
   output logic mosi,
   output logic rxDone,
   output logic [7:0] rxByte
);
   initial begin
      chipSelectLowN = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
      rxDone = 1'b0;
      rxByte = 8'h00;
   end
   task automatic half();
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
   // ==========================================================
   // one frame of n bits, msb first; last eight bits from miso kept
   task automatic frame(input logic [15:0] tx, input int n, input logic chk);
      logic [7:0] sh;
      sh = 8'h00;
      @(posedge clk_sys);
      #1;
      chipSelectLowN = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         mosi = tx[i];
         half();
         sclk = 1'b1;
         sh = {sh[6:0], miso};
         half();
         sclk = 1'b0;
      end
      half();
      chipSelectLowN = 1'b1;
      mosi = ~mosi; // last bit inverted, no stale value held
      rxByte = sh;
      if (chk) begin
         // one clock only, so the bench monitor takes exactly one note
         rxDone = 1'b1;
         @(posedge clk_sys);
         #1;
         rxDone = 1'b0;
      end
      half();
   endtask
   task automatic wr_status(input logic [7:0] d);
      frame({8'h00, CMD_WR_ENABLE}, 8, 1'b0);
      frame({CMD_WR_STATUS, d}, 16, 1'b0);
   endtask
   // four ready polls in a row, as for the largest part; bounded count
   task automatic poll_ready(output logic ok);
      int cnt;
      cnt = 0;
      for (int k = 0; k < 12 && cnt < 4; k++) begin
         frame({CMD_RD_FLAGS, 8'h00}, 16, 1'b0);
         cnt = rxByte[FS_READY] ? cnt + 1 : 0;
      end
      ok = (cnt == 4);
   endtask
endmodule

// ==== verification/test_flash_block_protect_status.sv ====
// self-checking bench: host model drives the link, bench drives op requests
// assumes status write scaled to 400 cycles; notes queued, checked by monitor
`timescale 1ns/1ps
module test_flash_block_protect_status import fbp_pkg::*;;
   typedef struct {logic [7:0] val; string nm;} fbp_note_t;
   logic clk_sys = 1'b0;
   logic nrst, chipSelectLowN, sclk, mosi, miso, misoOe, rxDone, ok, tb, errE, errW, errP;
   logic [7:0] rxByte;
   logic [3:0] code;
   logic [10:0] s;
   logic [31:0] seed = 32'd26;
   logic [31:0] r;
   fbp_dev_state_t ds;
   fbp_op_req_t opReq;
   fbp_op_rsp_t opRsp;
   fbp_note_t expQ[$];
   fbp_note_t n;
   int miscompares = 0;
   int numChecks = 0;
   int cyc = 0;
   int sz;
   always #25 clk_sys = ~clk_sys;
   fbp_protect_status #(.STATUS_CYCLES(400)) uut (.clk_sys(clk_sys), .nrst(nrst),
      .chipSelectLowN(chipSelectLowN), .sclk(sclk), .mosi(mosi), .miso(miso), .misoOe(misoOe),
      .devState(ds), .opReq(opReq), .opRsp(opRsp));
   fbp_host_model host (.clk_sys(clk_sys), .miso(miso), .chipSelectLowN(chipSelectLowN),
      .sclk(sclk), .mosi(mosi), .rxDone(rxDone), .rxByte(rxByte));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic prot(input logic [10:0] sec);
      if (code == 4'h0) return 1'b0;
      if (code >= PROT_ALL_CODE) return 1'b1;
      return tb ? (int'(sec) < sz) : (int'(sec) >= 2048 - sz);
   endfunction
   function automatic logic [7:0] flags(input logic rdy);
      return {rdy, ds.eraseSusp, errE | ds.eraseFail, errW | ds.progFail, 1'b0, ds.progSusp, errP, ds.addr4};
   endfunction
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      numChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [7:0] exp, input string nm);
      expQ.push_back('{exp, nm});
      host.frame({cmd, 8'h00}, 16, 1'b1);
      check("misoOeIdle", {7'h00, misoOe}, 8'h00);
   endtask
   task automatic pop_note();
      if (expQ.size() > 0) begin
         n = expQ.pop_front();
      end else begin
         n.val = 8'hXX;
         n.nm = "unexpected";
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ==========================================================
   // monitor: oldest note against each result that shows
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 80000) begin
         miscompares++;
         end_of_test();
      end else if (opReq.valid === 1'b1) begin
         pop_note();
         check(n.nm, {6'h00, opRsp}, n.val);
      end else if (rxDone === 1'b1) begin
         pop_note();
         check(n.nm, rxByte, n.val);
         // chip select rise not yet through the synchroniser here
         check("misoOe", {7'h00, misoOe}, 8'h01);
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      nrst = 1'b0;
      opReq = '0;
      ds = '0;
      repeat (4) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
      rd(CMD_RD_FLAGS, 8'h80, "flags");
      host.frame({8'h00, CMD_WR_ENABLE}, 8, 1'b0);
      rd(CMD_RD_STATUS, 8'h02, "welSet");
      // latch dropped again, so the status write below must be refused
      host.frame({8'h00, CMD_WR_DISABLE}, 8, 1'b0);
      host.frame({CMD_WR_STATUS, 8'h7C}, 16, 1'b0);
      rd(CMD_RD_STATUS, 8'h00, "status");
      $display("reset and refused write done");
      for (int i = 0; i < 32; i++) begin
         code = 4'(i);
         tb = i[4];
         r = rnd();
         ds = '{1'b0, 1'b0, 1'b0, r[0], r[1], r[2], r[3], r[4]};
         {errE, errW, errP} = 3'b000;
         host.wr_status({r[7], code[3], tb, code[2:0], r[6:5]});
         rd(CMD_RD_FLAGS, flags(1'b0), "busyFlags");
         host.poll_ready(ok);
         check("ready", {7'h00, ok}, 8'h01);
         rd(CMD_RD_STATUS, {1'b0, code[3], tb, code[2:0], 2'b00}, "status");
         sz = (code == 4'h0) ? 1 : (code >= PROT_ALL_CODE) ? 2048 : 1 << (code - 1);
         @(posedge clk_sys);
         #1;
         for (int j = 0; j < 5; j++) begin
            s = (j < 2) ? 11'(sz - 1 + j) : (j < 4) ? 11'(2045 + j - sz) : r[26:16];
            expQ.push_back('{{6'h00, ~prot(s), prot(s)}, "opRsp"});
            errP |= prot(s);
            errE |= prot(s) & r[8 + j];
            errW |= prot(s) & ~r[8 + j];
            opReq = '{1'b1, r[8 + j], s};
            @(posedge clk_sys);
            #1;
         end
         opReq.valid = 1'b0;
         rd(CMD_RD_FLAGS, flags(1'b1), "flags");
      end
      $display("protect codes done");
      ds.progBusy = 1'b1;
      rd(CMD_RD_FLAGS, flags(1'b0), "busyFlags");
      rd(CMD_RD_STATUS, {1'b0, code[3], tb, code[2:0], 2'b01}, "status");
      $display("external busy done");
      repeat (10) @(posedge clk_sys);
      end_of_test();
   end
endmodule
